// ==== design/hpi_pad_iso.sv ====
// Host port pad buffer control with power-loss isolation
module hpi_pad_iso (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic host_port_enable_pin_in,
    input wire logic boot_mode_strap_in,
    input wire logic host_chip_select_n_in,
    input wire logic host_register_select_in,
    input wire logic host_write_strobe_n_in,
    input wire logic host_read_strobe_n_in,
    input wire logic host_ready_pad_in,
    input wire logic host_interrupt_pad_in,
    input wire logic host_dma_request_pad_in,
    input wire logic [15:0] host_data_bus_in,
    input wire logic pin_func_sel_enable_in,
    input wire logic [7:0] pin_func_sel_host_in,
    input wire logic core_ready_in,
    input wire logic core_interrupt_in,
    input wire logic core_dma_request_in,
    input wire logic [15:0] core_data_tx_in,
    output logic host_ready_out,
    output logic host_ready_oe_out,
    output logic host_interrupt_out,
    output logic host_interrupt_oe_out,
    output logic host_dma_request_out,
    output logic host_dma_request_oe_out,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe_out,
    output logic host_data_bus_ie_out,
    output logic [3:0] host_strobe_ie_out,
    output logic [3:0] core_strobe_out,
    output logic [15:0] core_data_rx_out,
    output logic [7:0] gpio_level_out,
    output logic [15:0] gpio_data_out
);

    typedef struct packed {
        logic [7:0] s1_pin;
        logic [7:0] s2_pin;
        logic s1_strap;
        logic s2_strap;
        logic [15:0] s1_dat;
        logic [15:0] s2_dat;
        logic strap_r;
        logic rdy_o;
        logic rdy_oe;
        logic int_o;
        logic int_oe;
        logic dreq_o;
        logic dreq_oe;
        logic [15:0] dat_o;
        logic dat_oe;
        logic dat_ie;
        logic [3:0] stb_ie;
        logic [3:0] core_stb;
        logic [15:0] dat_rx;
        logic [7:0] gpio;
        logic [15:0] gpio_dat;
    } hpi_state_t;

    hpi_state_t r;
    hpi_state_t n;
    hpi_pkg::hpi_pad_t st [hpi_pkg::NUM_SEL];
    logic boot;
    logic en_sel;
    logic en_gpio;
    logic live;

    always_comb begin
        n = r;
        boot = 1'b0;
        en_sel = 1'b0;
        en_gpio = 1'b0;
        live = 1'b0;
        n.s1_pin = {host_port_enable_pin_in, host_read_strobe_n_in,
                    host_write_strobe_n_in, host_register_select_in,
                    host_chip_select_n_in, host_dma_request_pad_in,
                    host_interrupt_pad_in, host_ready_pad_in};
        n.s2_pin = r.s1_pin;
        n.s1_strap = boot_mode_strap_in;
        n.s2_strap = r.s1_strap;
        n.s1_dat = host_data_bus_in;
        n.s2_dat = r.s1_dat;

        // Strap is caught while reset is held and frozen at release
        boot = rst_in ? r.s2_strap : r.strap_r;
        en_sel = boot | pin_func_sel_enable_in;
        if (rst_in) begin
            n.strap_r = r.s2_strap;
            en_gpio = !boot;
            for (int i = 0; i < hpi_pkg::NUM_SEL; i++) begin
                st[i] = boot ? hpi_pkg::PAD_OFF : hpi_pkg::PAD_GPIO;
            end
        end else begin
            en_gpio = !en_sel;
            for (int i = 0; i < hpi_pkg::NUM_SEL; i++) begin
                // Boot strap forces host use; otherwise selections decide
                st[i] = hpi_pkg::pad_mode(boot | pin_func_sel_host_in[i],
                                          en_sel,
                                          r.s2_pin[hpi_pkg::PIN_EN]);
            end
        end

        // Ready is the one pin driven during boot reset
        n.rdy_oe = (st[hpi_pkg::SEL_RDY] == hpi_pkg::PAD_LIVE)
                   | (rst_in & boot);
        n.rdy_o = (st[hpi_pkg::SEL_RDY] == hpi_pkg::PAD_LIVE) ?
                  core_ready_in : hpi_pkg::RST_READY_LEVEL;
        n.int_oe = (st[hpi_pkg::SEL_INT] == hpi_pkg::PAD_LIVE);
        n.int_o = n.int_oe & core_interrupt_in;
        n.dreq_oe = (st[hpi_pkg::SEL_DREQ] == hpi_pkg::PAD_LIVE);
        n.dreq_o = n.dreq_oe & core_dma_request_in;

        // Idle strobes keep the core quiet while a pin is isolated
        for (int s = 0; s < hpi_pkg::NUM_STB; s++) begin
            n.stb_ie[s] = st[hpi_pkg::SEL_CS + s] == hpi_pkg::PAD_LIVE;
            n.core_stb[s] = n.stb_ie[s] ? r.s2_pin[hpi_pkg::SEL_CS + s] :
                            hpi_pkg::STROBE_IDLE[s];
        end

        // Data turns round on synchronised strobes; adds two cycles lag
        live = (st[hpi_pkg::SEL_DATA] == hpi_pkg::PAD_LIVE);
        n.dat_ie = live;
        n.dat_oe = live & !r.s2_pin[hpi_pkg::SEL_CS]
                   & !r.s2_pin[hpi_pkg::SEL_RD];
        n.dat_o = live ? core_data_tx_in : '0;
        n.dat_rx = live ? r.s2_dat : '0;

        for (int i = 0; i < hpi_pkg::SEL_DATA; i++) begin
            n.gpio[i] = (st[i] == hpi_pkg::PAD_GPIO) & r.s2_pin[i];
        end
        n.gpio[hpi_pkg::PIN_EN] = en_gpio & r.s2_pin[hpi_pkg::PIN_EN];
        n.gpio_dat = (st[hpi_pkg::SEL_DATA] == hpi_pkg::PAD_GPIO) ?
                     r.s2_dat : '0;
    end

    // Reset is synchronous and handled in the next-state logic
    always_ff @(posedge clk_in) begin
        r <= n;
    end

    assign host_ready_out = r.rdy_o;
    assign host_ready_oe_out = r.rdy_oe;
    assign host_interrupt_out = r.int_o;
    assign host_interrupt_oe_out = r.int_oe;
    assign host_dma_request_out = r.dreq_o;
    assign host_dma_request_oe_out = r.dreq_oe;
    assign host_data_bus_out = r.dat_o;
    assign host_data_bus_oe_out = r.dat_oe;
    assign host_data_bus_ie_out = r.dat_ie;
    assign host_strobe_ie_out = r.stb_ie;
    assign core_strobe_out = r.core_stb;
    assign core_data_rx_out = r.dat_rx;
    assign gpio_level_out = r.gpio;
    assign gpio_data_out = r.gpio_dat;

    sequence s_en_low;
        !host_port_enable_pin_in [*3];
    endsequence

    sequence s_en_high;
        host_port_enable_pin_in [*3];
    endsequence

    sequence s_read_cycle;
        (host_port_enable_pin_in && !host_chip_select_n_in
         && !host_read_strobe_n_in) [*3];
    endsequence

    property p_iso_all;
        @(posedge clk_in) disable iff (rst_in)
        (r.strap_r ##0 s_en_low) |=> (!host_ready_oe_out
            && !host_interrupt_oe_out && !host_dma_request_oe_out
            && !host_data_bus_oe_out && !host_data_bus_ie_out
            && host_strobe_ie_out == 4'h0
            && core_strobe_out == hpi_pkg::STROBE_IDLE);
    endproperty
    a_iso_all: assert property (p_iso_all)
        else $error("pins not isolated");

    property p_live_gate;
        @(posedge clk_in) disable iff (rst_in)
        (r.strap_r ##0 s_en_high) |=> (host_strobe_ie_out == 4'hf
            && host_interrupt_oe_out && host_data_bus_ie_out);
    endproperty
    a_live_gate: assert property (p_live_gate)
        else $error("buffers not live");

    property p_no_enable_sel;
        @(posedge clk_in) disable iff (rst_in)
        (!r.strap_r && !pin_func_sel_enable_in && pin_func_sel_host_in[0]
         && pin_func_sel_host_in[3]) |=> (!host_ready_oe_out
            && !host_strobe_ie_out[0] && !gpio_level_out[0]);
    endproperty
    a_no_enable_sel: assert property (p_no_enable_sel)
        else $error("pin not off");

    property p_strap_low_reset;
        @(posedge clk_in)
        (rst_in && !r.s2_strap) |=> (!host_ready_oe_out
            && !host_data_bus_oe_out && host_strobe_ie_out == 4'h0
            && gpio_data_out == $past(r.s2_dat));
    endproperty
    a_strap_low_reset: assert property (p_strap_low_reset)
        else $error("not general input");

    property p_enable_role;
        @(posedge clk_in) disable iff (rst_in)
        (!r.strap_r && pin_func_sel_enable_in && pin_func_sel_host_in[6]
         ##0 s_en_high) |=> (host_strobe_ie_out[3] && !gpio_level_out[7]);
    endproperty
    a_enable_role: assert property (p_enable_role)
        else $error("enable role lost");

    property p_host_role;
        @(posedge clk_in) disable iff (rst_in)
        (!r.strap_r && !pin_func_sel_host_in[4]) |=> (!host_strobe_ie_out[1]
            && gpio_level_out[4] == $past(r.s2_pin[4]));
    endproperty
    a_host_role: assert property (p_host_role)
        else $error("general input lost");

    property p_boot_reset;
        @(posedge clk_in)
        (rst_in && r.s2_strap) |=> (host_ready_oe_out && !host_ready_out
            && !host_interrupt_oe_out && !host_dma_request_oe_out
            && !host_data_bus_oe_out && host_strobe_ie_out == 4'h0);
    endproperty
    a_boot_reset: assert property (p_boot_reset)
        else $error("reset drive wrong");

    property p_read_drive;
        @(posedge clk_in) disable iff (rst_in)
        (r.strap_r ##0 s_read_cycle) |=> (host_data_bus_oe_out
            && host_data_bus_out == $past(core_data_tx_in));
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("data not driven");

    property p_ready_follow;
        @(posedge clk_in) disable iff (rst_in)
        (r.strap_r ##0 s_en_high) |=> (host_ready_oe_out
            && host_ready_out == $past(core_ready_in));
    endproperty
    a_ready_follow: assert property (p_ready_follow)
        else $error("ready not seq");

endmodule

// ==== design/hpi_pkg.sv ====
// Constants, pad mode type and decode function for host port pad isolation
package hpi_pkg;

    localparam int NUM_SEL = 8;
    localparam int DATA_W = 16;

    // Selection and synchronised pin indices share positions 0 to 6
    localparam int SEL_RDY = 0;
    localparam int SEL_INT = 1;
    localparam int SEL_DREQ = 2;
    localparam int SEL_CS = 3;
    localparam int SEL_RS = 4;
    localparam int SEL_WR = 5;
    localparam int SEL_RD = 6;
    localparam int SEL_DATA = 7;
    localparam int PIN_EN = 7;
    localparam int NUM_STB = 4;

    // Strobe levels handed to the core while a strobe buffer is off
    localparam logic [3:0] STROBE_IDLE = 4'hd;
    localparam logic RST_READY_LEVEL = 1'h0;

    typedef enum logic [2:0] {
        PAD_GPIO = 3'h1,
        PAD_OFF = 3'h2,
        PAD_LIVE = 3'h4
    } hpi_pad_t;

    function automatic hpi_pad_t pad_mode(input logic host_sel,
                                          input logic en_sel,
                                          input logic en_level);
        if (!host_sel) begin
            pad_mode = PAD_GPIO;
        end else if (!en_sel) begin
            pad_mode = PAD_OFF;
        end else if (!en_level) begin
            pad_mode = PAD_OFF;
        end else begin
            pad_mode = PAD_LIVE;
        end
    endfunction

endpackage

// ==== tb/host_port_pad_isolation_tb.sv ====
// Bench for host port pad isolation with host and power monitor model
module host_port_pad_isolation_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic strap = 1'b1;
    logic power_on = 1'b0;
    logic read_req = 1'b0;
    logic sel_en = 1'b0;
    logic [7:0] sel_host = 8'h00;
    logic core_rdy = 1'b0;
    logic core_int = 1'b0;
    logic [15:0] core_tx = 16'h3c96;
    logic en_pin, cs_n, rd_n, wr_n, rs;
    logic rdy, rdy_oe, irq, irq_oe, dreq, dreq_oe, d_oe, d_ie;
    logic [15:0] pad_data, d_out, rx, gdata;
    logic [3:0] stb_ie, stb;
    logic [7:0] glvl;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;

    hpi_host_model u_hpi_host_model (.clk_in(clk_in),
        .power_on_in(power_on), .read_in(read_req),
        .enable_pin_out(en_pin), .chip_select_n_out(cs_n),
        .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
        .register_select_out(rs), .data_out(pad_data));

    hpi_pad_iso u_hpi_pad_iso (.clk_in(clk_in), .rst_in(rst_in),
        .host_port_enable_pin_in(en_pin), .boot_mode_strap_in(strap),
        .host_chip_select_n_in(cs_n), .host_register_select_in(rs),
        .host_write_strobe_n_in(wr_n), .host_read_strobe_n_in(rd_n),
        .host_ready_pad_in(1'b1), .host_interrupt_pad_in(1'b0),
        .host_dma_request_pad_in(1'b1), .host_data_bus_in(pad_data),
        .pin_func_sel_enable_in(sel_en),
        .pin_func_sel_host_in(sel_host),
        .core_ready_in(core_rdy), .core_interrupt_in(core_int),
        .core_dma_request_in(core_int), .core_data_tx_in(core_tx),
        .host_ready_out(rdy), .host_ready_oe_out(rdy_oe),
        .host_interrupt_out(irq), .host_interrupt_oe_out(irq_oe),
        .host_dma_request_out(dreq), .host_dma_request_oe_out(dreq_oe),
        .host_data_bus_out(d_out), .host_data_bus_oe_out(d_oe),
        .host_data_bus_ie_out(d_ie), .host_strobe_ie_out(stb_ie),
        .core_strobe_out(stb), .core_data_rx_out(rx),
        .gpio_level_out(glvl), .gpio_data_out(gdata));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    function automatic logic [15:0] st();
        st = {6'h0, rdy_oe, rdy, irq_oe, dreq_oe, d_oe, d_ie, stb_ie};
    endfunction

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic do_reset(input logic s, input logic pw);
        @(posedge clk_in);
        rst_in <= 1'b1;
        strap <= s;
        power_on <= pw;
        settle(12);
        chk("reset pads", st(), s ? 16'h0200 : 16'h0000);
        chk("reset gpio", 16'(glvl), s ? 16'h0000 : {8'h00, pw, 7'h6d});
        @(posedge clk_in);
        rst_in <= 1'b0;
    endtask

    task automatic test_boot_iso();
        do_reset(1'b1, 1'b0);
        settle(5);
        chk("isolated", st(), 16'h0000);
        chk("idle strobes", 16'(stb), 16'h000d);
        chk("gpio off", 16'(glvl), 16'h0000);
        chk("gpio data off", gdata, 16'h0000);
        @(posedge clk_in);
        power_on <= 1'b1;
        core_rdy <= 1'b1;
        core_int <= 1'b1;
        settle(6);
        chk("live", st(), 16'h03df);
        chk("sequence", {13'h0000, rdy, irq, dreq}, 16'h0007);
        @(posedge clk_in);
        read_req <= 1'b1;
        settle(6);
        chk("read oe", st(), 16'h03ff);
        chk("read data", d_out, core_tx);
        chk("read strobes", 16'(stb), 16'h0006);
        // Pad data toggles each cycle and lags three edges: inverse
        chk("live data", rx, ~pad_data);
        @(posedge clk_in);
        power_on <= 1'b0;
        settle(6);
        chk("cut pads", st(), 16'h0000);
        chk("cut strobes", 16'(stb), 16'h000d);
        chk("cut data", rx, 16'h0000);
        @(posedge clk_in);
        read_req <= 1'b0;
        $display("test_boot_iso done");
    endtask

    task automatic test_gpio_mode();
        do_reset(1'b0, 1'b1);
        settle(5);
        chk("gpio pads", st(), 16'h0000);
        chk("gpio levels", 16'(glvl), 16'h00ed);
        chk("gpio data", gdata, ~pad_data);
        @(posedge clk_in);
        // Forbidden pairing on purpose: pins must stay off
        sel_host <= 8'h09;
        settle(4);
        chk("no enable role", st(), 16'h0000);
        chk("no enable gpio", 16'(glvl), 16'h00e4);
        @(posedge clk_in);
        sel_en <= 1'b1;
        settle(4);
        chk("ready live", st(), 16'h0301);
        chk("enable role", 16'(glvl), 16'h0064);
        @(posedge clk_in);
        sel_host <= 8'hff;
        settle(4);
        chk("all host", st(), 16'h03df);
        chk("all host gpio", 16'(glvl), 16'h0000);
        @(posedge clk_in);
        power_on <= 1'b0;
        settle(6);
        chk("gated off", st(), 16'h0000);
        do_reset(1'b1, 1'b1);
        $display("test_gpio_mode done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Run needs about 96 cycles; ceiling leaves wide margin
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        test_boot_iso();
        test_gpio_mode();
        end_of_test();
    end
endmodule

// ==== tb/hpi_host_model.sv ====
// Power monitor and external host model driving the host port pads
module hpi_host_model (
    input wire logic clk_in,
    input wire logic power_on_in,
    input wire logic read_in,
    output logic enable_pin_out,
    output logic chip_select_n_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic register_select_out,
    output logic [15:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        enable_pin_out = 1'b0;
        chip_select_n_out = 1'b1;
        read_strobe_n_out = 1'b1;
        write_strobe_n_out = 1'b1;
        register_select_out = 1'b0;
        data_out = 16'h5a5a;
    end
    // Strobes stay active across a power cut, so isolation must block them
    always @(posedge clk_in) begin
        enable_pin_out <= power_on_in;
        chip_select_n_out <= !read_in;
        read_strobe_n_out <= !read_in;
        register_select_out <= read_in;
        data_out <= ~data_out;
    end
endmodule
